//--- pkg/aps_pkg.sv
// shared constants and types for the audio serial output port
package aps_pkg;
    // --------------------------------------------------------------
    // formats and sampling modes
    // --------------------------------------------------------------
    typedef enum logic [1:0] {FMT_LJ, FMT_I2S, FMT_TDM, FMT_TDM_DLY} aps_fmt_e;
    typedef enum logic [1:0] {RATE_NORMAL, RATE_DOUBLE, RATE_QUAD, RATE_RSVD} aps_rate_e;

    // --------------------------------------------------------------
    // widths and frame geometry
    // --------------------------------------------------------------
    localparam int          SAMPLE_W      = 24;
    localparam int          SLOT_W        = 32;
    localparam int          PAIR_W        = 2 * SAMPLE_W;
    localparam int          FIFO_DEPTH    = 2;
    localparam logic [4:0]  WL_24         = 5'h18;
    localparam logic [4:0]  WL_18         = 5'h12;
    localparam logic [4:0]  WL_20         = 5'h14;
    localparam logic [4:0]  WL_16         = 5'h10;

    // --------------------------------------------------------------
    // clock ratios (sys_clk counted at twice the master clock)
    // --------------------------------------------------------------
    localparam logic [9:0]  SYS_PER_FS_NORMAL = 10'h200;
    localparam logic [8:0]  BCK_LJ_NORMAL     = 9'h080;
    localparam logic [8:0]  BCK_LJ_FAST       = 9'h040;
    localparam logic [8:0]  BCK_TDM_NORMAL    = 9'h100;
    localparam logic [7:0]  HALF_SLOW         = 8'h02;
    localparam logic [7:0]  HALF_FAST         = 8'h01;

    // --------------------------------------------------------------
    // filters and dither
    // --------------------------------------------------------------
    localparam int          HPF_CORNER_DIV = 48000;
    // fs / (2*pi*2^13) lands close to fs / 48000
    localparam int          HPF_SHIFT      = 13;
    localparam int          HP_ACC_W       = SAMPLE_W + HPF_SHIFT + 2;
    localparam logic [5:0]  GD_CLASSIC     = 6'h27;
    localparam logic [5:0]  GD_LOW_LATENCY = 6'h15;
    localparam logic [15:0] RNG_SEED_A     = 16'hACE1;
    localparam logic [15:0] RNG_SEED_B     = 16'h5A3C;
endpackage

//--- verilog/aps_serial_out.sv
// audio serial output port: formats, tdm slots, high-pass, dither
`timescale 1ns/1ps

// Contract
// - format pins pick left-justified, i2s, tdm or tdm delayed by one bit
// - samples go out as two's complement, msb first
// - serial data changes only on bit clock falling edges
// - word select runs at exactly the sample rate, either side generating it
// - slave: clocks are inputs; master: device divides both from master clock
// - master lj/i2s bit clock is 128 fs normal, 64 fs double and quad
// - tdm bit clock is 256, 128, 64 fs for normal, double, quad
// - tdm frame carries at most eight, four, two channels by rate
// - sub-frame pins place the output in tdm sub-frame 0 to 3
// - sub-frame is two 32-bit slots, 24 data bits left-justified, rest follow
// - delayed tdm starts data one bit clock after word select rises
// - filter pin: low classic delay 39, high low-latency delay 21
// - quad speed always uses low-latency response, filter pin ignored
// - per-channel high-pass disable pin: low filters, high bypasses
// - high-pass corner is about sample rate over 48000
// - word length pins give 24, 18, 20 or 16 bits
// - shorter words get triangular dither before truncation
// - disabled or in reset: serial data and clock outputs driven low
// - rate pins give normal, double, quad; both high reserved
module aps_serial_out
    import aps_pkg::*;
(
    input  wire logic                sys_clk,
    input  wire logic                rst_n,
    input  wire logic                pcmOutputEnable,
    input  wire logic                masterMode,
    input  wire logic                formatSelLo,
    input  wire logic                formatSelHi,
    input  wire logic                rateModeSelLo,
    input  wire logic                rateModeSelHi,
    input  wire logic                subframeSelLo,
    input  wire logic                subframeSelHi,
    input  wire logic                filterResponseSel,
    input  wire logic                leftHighpassDisable,
    input  wire logic                rightHighpassDisable,
    input  wire logic                wordLengthSelLo,
    input  wire logic                wordLengthSelHi,
    input  wire logic [SAMPLE_W-1:0] sampleLeft,
    input  wire logic [SAMPLE_W-1:0] sampleRight,
    input  wire logic                sampleValid,
    output logic                     sampleReady,
    input  wire logic                bitClockIn,
    output logic                     bitClockOut,
    output logic                     bitClockOe,
    input  wire logic                wordSelectIn,
    output logic                     wordSelectOut,
    output logic                     wordSelectOe,
    output logic                     serialData,
    output logic                     filterLowLatency,
    output logic [5:0]               groupDelaySamples
);
    // ----------------------------------------------------------------
    // state
    // ----------------------------------------------------------------
    typedef struct packed {
        logic                           bckPrev;
        logic                           wsPrev;
        logic [8:0]                     bitCnt;
        logic                           serData;
        logic                           bckOut;
        logic                           wsOut;
        logic [7:0]                     halfCnt;
        logic [8:0]                     mCnt;
        logic [SAMPLE_W-1:0]            txL;
        logic [SAMPLE_W-1:0]            txR;
        logic [HP_ACC_W-1:0]            hpL;
        logic [HP_ACC_W-1:0]            hpR;
        logic [15:0]                    rngA;
        logic [15:0]                    rngB;
        logic [FIFO_DEPTH-1:0][PAIR_W-1:0] mem;
        logic                           wrPtr;
        logic                           rdPtr;
        logic [1:0]                     fill;
        logic                           lowLat;
    } aps_state_s;

    aps_state_s          q, d;
    aps_fmt_e            fmt;
    aps_rate_e           rate;
    logic                isTdm, dly, isI2s, bckLvl, wsLvl, fall, wsEdge, frameStart;
    logic                push, pop, leftCh, active;
    logic [8:0]          bits, pos, cnt;
    logic [9:0]          sysPerFs;
    logic [7:0]          halfLimit;
    logic [4:0]          wordLen, bitIdx;
    logic [1:0]          subSel;
    logic [SAMPLE_W-1:0] mask, word;
    logic [15:0]         rA, rB;

    // dc removal then dither; returns {new accumulator, output sample}
    function automatic logic [HP_ACC_W+SAMPLE_W-1:0] shape(
        input logic [SAMPLE_W-1:0] x,
        input logic [HP_ACC_W-1:0] acc,
        input logic                bypass,
        input logic [SAMPLE_W-1:0] m,
        input logic [15:0]         ra,
        input logic [15:0]         rb
    );
        logic signed [HP_ACC_W-1:0]   dc, diff, xe;
        logic signed [SAMPLE_W+1:0]   y, dith;
        logic        [SAMPLE_W-1:0]   ys;
        dc   = $signed(acc) >>> HPF_SHIFT;
        xe   = HP_ACC_W'($signed(x));
        diff = xe - dc;
        y    = bypass ? (SAMPLE_W+2)'($signed(x)) : diff[SAMPLE_W+1:0];
        dith = $signed({2'b00, ra[SAMPLE_W-9:0] & m[15:0]})
             - $signed({2'b00, rb[SAMPLE_W-9:0] & m[15:0]});
        y    = y + dith;
        if (y > $signed({3'b000, {(SAMPLE_W-1){1'b1}}})) begin
            ys = {1'b0, {(SAMPLE_W-1){1'b1}}};
        end else if (y < -$signed({3'b001, {(SAMPLE_W-1){1'b0}}})) begin
            ys = {1'b1, {(SAMPLE_W-1){1'b0}}};
        end else begin
            ys = y[SAMPLE_W-1:0];
        end
        // acc tracks dc with a 2^-13 step, setting the corner near fs/48000
        shape = {acc + HP_ACC_W'(diff), ys & ~m};
    endfunction

    // ----------------------------------------------------------------
    // pin decode
    // ----------------------------------------------------------------
    always_comb begin
        fmt    = aps_fmt_e'({formatSelHi, formatSelLo});
        rate   = aps_rate_e'({rateModeSelHi, rateModeSelLo});
        if (rate == RATE_RSVD) begin
            rate = RATE_NORMAL;
        end
        isTdm  = fmt == FMT_TDM || fmt == FMT_TDM_DLY;
        isI2s  = fmt == FMT_I2S;
        dly    = isI2s || fmt == FMT_TDM_DLY;
        subSel = {subframeSelHi, subframeSelLo};
        case ({wordLengthSelHi, wordLengthSelLo})
            2'b01:   wordLen = WL_18;
            2'b10:   wordLen = WL_20;
            2'b11:   wordLen = WL_16;
            default: wordLen = WL_24;
        endcase
        mask     = ~({SAMPLE_W{1'b1}} << (WL_24 - wordLen));
        sysPerFs = SYS_PER_FS_NORMAL >> rate;
        if (isTdm) begin
            bits = BCK_TDM_NORMAL >> rate;
        end else begin
            bits = (rate == RATE_NORMAL) ? BCK_LJ_NORMAL : BCK_LJ_FAST;
        end
        halfLimit = (!isTdm && rate != RATE_QUAD) ? HALF_SLOW : HALF_FAST;
    end

    // ----------------------------------------------------------------
    // next state
    // ----------------------------------------------------------------
    always_comb begin
        d           = q;
        rA          = (q.rngA == 16'h0000) ? RNG_SEED_A : q.rngA;
        rB          = (q.rngB == 16'h0000) ? RNG_SEED_B : q.rngB;
        sampleReady = q.fill != 2'(FIFO_DEPTH);
        push        = sampleValid && sampleReady;
        d.lowLat    = filterResponseSel || rate == RATE_QUAD;
        // master divides sys_clk into both clocks
        if (masterMode) begin
            if (q.halfCnt >= halfLimit - 8'h01) begin
                d.halfCnt = 8'h00;
                d.bckOut  = ~q.bckOut;
                if (q.bckOut) begin
                    d.mCnt  = (q.mCnt + 9'h001 >= bits) ? 9'h000 : q.mCnt + 9'h001;
                    // word select toggles at half frame: exactly fs
                    d.wsOut = (d.mCnt < (bits >> 1)) ^ isI2s;
                end
            end else begin
                d.halfCnt = q.halfCnt + 8'h01;
            end
        end else begin
            d.bckOut = 1'b0;
            d.wsOut  = 1'b0;
        end
        bckLvl    = masterMode ? d.bckOut : bitClockIn;
        wsLvl     = masterMode ? d.wsOut : wordSelectIn;
        d.bckPrev = bckLvl;
        fall      = q.bckPrev && !bckLvl;
        wsEdge    = isTdm ? (wsLvl && !q.wsPrev) : (wsLvl != q.wsPrev);
        // lj frames open on ws high, i2s on ws low (left first)
        frameStart = fall && wsEdge && (isTdm || (wsLvl ^ isI2s));
        pop        = frameStart && q.fill != 2'b00;
        cnt        = wsEdge ? 9'h000 : q.bitCnt + 9'h001;
        pos        = cnt - {8'h00, dly};
        bitIdx     = pos[4:0];
        leftCh     = isTdm ? !pos[5] : (wsLvl ^ isI2s);
        active     = !(dly && cnt == 9'h000)
                  && (isTdm ? pos[8:6] == {1'b0, subSel} : pos[8:5] == 4'h0);
        if (pop) begin
            {d.hpL, d.txL} = shape(q.mem[q.rdPtr][PAIR_W-1:SAMPLE_W], q.hpL,
                                   leftHighpassDisable, mask, rA, rB);
            {d.hpR, d.txR} = shape(q.mem[q.rdPtr][SAMPLE_W-1:0], q.hpR,
                                   rightHighpassDisable, mask, rB, rA);
            d.rngA  = {rA[14:0], rA[15] ^ rA[13] ^ rA[12] ^ rA[10]};
            d.rngB  = {rB[14:0], rB[15] ^ rB[13] ^ rB[12] ^ rB[10]};
            d.rdPtr = ~q.rdPtr;
        end
        if (push) begin
            d.mem[q.wrPtr] = {sampleLeft, sampleRight};
            d.wrPtr        = ~q.wrPtr;
        end
        d.fill = q.fill + {1'b0, push} - {1'b0, pop};
        if (fall) begin
            d.wsPrev = wsLvl;
            d.bitCnt = cnt;
            word     = leftCh ? d.txL : d.txR;
            // msb first; bits past the word length and slot padding send zero
            d.serData = active && bitIdx < wordLen && word[5'(WL_24 - 5'h01 - bitIdx)];
        end else begin
            word = d.txL;
        end
        if (!pcmOutputEnable) begin
            d.serData = 1'b0;
            d.bckOut  = 1'b0;
            d.wsOut   = 1'b0;
            d.halfCnt = 8'h00;
            // first fall after enable wraps to zero, so the first frame is a full one
            d.mCnt    = bits - 9'h001;
            d.bitCnt  = 9'h000;
            // idle ws level, so the first edge away from it opens a frame
            d.wsPrev  = isI2s;
        end
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    // ----------------------------------------------------------------
    // outputs
    // ----------------------------------------------------------------
    assign serialData        = q.serData;
    assign bitClockOut       = q.bckOut;
    assign wordSelectOut     = q.wsOut;
    assign bitClockOe        = masterMode;
    assign wordSelectOe      = masterMode;
    assign filterLowLatency  = q.lowLat;
    assign groupDelaySamples = q.lowLat ? GD_LOW_LATENCY : GD_CLASSIC;

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    logic [9:0] wsPerQ;
    logic [8:0] fallsQ;
    logic [5:0] cfgQ;
    logic       seenQ, wsRise;
    assign wsRise = d.wsOut && !q.wsOut;

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            wsPerQ <= 10'h000;
            fallsQ <= 9'h000;
            cfgQ   <= 6'h00;
            seenQ  <= 1'b0;
        end else begin
            cfgQ   <= {fmt, rate, masterMode, pcmOutputEnable};
            wsPerQ <= wsRise ? 10'h000 : wsPerQ + 10'h001;
            fallsQ <= wsRise ? 9'h000 : fallsQ + {8'h00, fall};
            if (cfgQ != {fmt, rate, masterMode, pcmOutputEnable}) begin
                seenQ <= 1'b0;
            end else if (wsRise) begin
                seenQ <= 1'b1;
            end
        end
    end

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_n);

    a_disabled_low: assert property (!pcmOutputEnable |=>
        !serialData && !bitClockOut && !wordSelectOut) else $error("outputs not low");
    a_data_on_fall: assert property ($changed(serialData) && $past(pcmOutputEnable)
        |-> $past(fall)) else $error("data moved off a falling edge");
    a_ws_frame_rate: assert property (masterMode && wsRise && seenQ
        |-> wsPerQ + 10'h001 == sysPerFs) else $error("word select not at fs");
    a_bck_per_frame: assert property (masterMode && wsRise && seenQ && !isTdm
        |-> fallsQ + 9'h001 == ((rate == RATE_NORMAL) ? 9'h080 : 9'h040))
        else $error("lj/i2s bit clock ratio wrong");
    a_tdm_bck_ratio: assert property (masterMode && wsRise && seenQ && isTdm
        |-> fallsQ + 9'h001 == (9'h100 >> rate)) else $error("tdm bit clock ratio wrong");
    a_tdm_slot_own: assert property (serialData && $past(isTdm)
        |-> $past(pos[8:6]) == {1'b0, $past(subSel)}) else $error("data outside sub-frame");
    a_word_length: assert property (serialData && $past(fall)
        |-> $past(bitIdx) < $past(wordLen)) else $error("bit beyond word length");
    a_tdm_delay_gap: assert property (fall && wsEdge && fmt == FMT_TDM_DLY && pcmOutputEnable
        |=> !serialData) else $error("delayed tdm sent data on edge");
    a_dither_trunc: assert property ($past(pop)
        |-> ((q.txL | q.txR) & $past(mask)) == '0) else $error("low bits not truncated");
    a_quad_lowlat: assert property ($past(rate) == RATE_QUAD |-> filterLowLatency)
        else $error("quad mode not low latency");

    c_master_frame: cover property (masterMode && wsRise && seenQ);
    c_tdm_data: cover property (isTdm && serialData);
    c_fifo_full: cover property (q.fill == 2'b10 && sampleValid);
    c_short_word: cover property (pop && wordLen == WL_16);
endmodule

//--- verif/aps_host_model.sv
// audio host model: slave clock source and serial frame receiver
`timescale 1ns/1ps
module aps_host_model (
    input  wire logic         sys_clk,
    input  wire logic         run,
    input  wire logic         startOnFall,
    input  wire logic [7:0]   halfSys,
    input  wire logic [8:0]   bitsPerFrame,
    input  wire logic         linkBck,
    input  wire logic         linkWs,
    input  wire logic         serialIn,
    output logic              hostBck,
    output logic              hostWs,
    output logic [255:0]      frameBits,
    output int                frameLen,
    output int                frameSys,
    output int                frameCount
);
    int           div = 0;
    int           bitCnt = 0;
    int           sysCnt = 0;
    int           lastStart = 0;
    int           idx = 0;
    logic         wsPrev = 1'b0;
    logic         started = 1'b0;
    logic [255:0] bits = '0;

    initial begin
        hostBck = 1'b0;
        hostWs = 1'b0;
        frameCount = 0;
    end
    // ------------------------------------------------------------
    // slave clocks: stand still outside a run
    // ------------------------------------------------------------
    always @(posedge sys_clk) begin
        #1;
        if (!run) begin
            hostBck = 1'b0;
            hostWs = startOnFall;
            div = 0;
            bitCnt = 0;
        end else if (++div >= int'(halfSys)) begin
            div = 0;
            hostBck = !hostBck;
            if (!hostBck && ++bitCnt >= int'(bitsPerFrame) / 2) begin
                bitCnt = 0;
                hostWs = !hostWs;
            end
        end
    end
    always @(negedge sys_clk) sysCnt++;
    // ------------------------------------------------------------
    // receiver: bits taken on rising bit clock
    // ------------------------------------------------------------
    always @(posedge linkBck or negedge run) begin
        if (!run) begin
            started = 1'b0;
            frameCount = 0;
        end else begin
            // idle level of ws differs per format, so the first edge away from it starts
            if (linkWs != startOnFall && (!started || linkWs != wsPrev)) begin
                if (started) begin
                    frameBits = bits;
                    frameLen = idx;
                    frameSys = sysCnt - lastStart;
                    frameCount++;
                end
                started = 1'b1;
                idx = 0;
                lastStart = sysCnt;
                bits = '0;
            end
            if (idx < 256) bits[idx] = serialIn;
            idx++;
            wsPrev = linkWs;
        end
    end
endmodule

//--- verif/tb_top.sv
// self-checking bench for the audio serial output port
`timescale 1ns/1ps
module tb_top;
    import aps_pkg::*;
    logic                sys_clk = 1'b0;
    logic                rst_n = 1'b0;
    logic                pcmOutputEnable = 1'b0;
    logic                masterMode = 1'b1;
    logic [1:0]          fmtSel = 2'h0;
    logic [1:0]          rateSel = 2'h0;
    logic [1:0]          subSel = 2'h0;
    logic [1:0]          wlSel = 2'h0;
    logic                filterResponseSel = 1'b0;
    logic                leftHpDis = 1'b1;
    logic                rightHpDis = 1'b1;
    logic [SAMPLE_W-1:0] sampleLeft = '0;
    logic [SAMPLE_W-1:0] sampleRight = '0;
    logic                sampleValid = 1'b0;
    logic                sampleReady, bitClockOut, bitClockOe, wordSelectOut, wordSelectOe;
    logic                serialData, filterLowLatency, hostBck, hostWs;
    logic [5:0]          groupDelaySamples;
    logic                run = 1'b0;
    logic                startOnFall = 1'b0;
    logic [7:0]          halfSys = 8'h01;
    logic [8:0]          bitsPerFrame = 9'h100;
    logic [255:0]        frameBits;
    int                  frameLen, frameSys, frameCount;
    int                  bad_count = 0;
    int                  tests_run = 0;
    int                  cycles = 0;
    int                  cfgCount = 0;
    logic [31:0]         rng = 32'hCA066660;
    logic [47:0]         pairQ[$];
    logic                readyPre = 1'b0;
    logic                prevBck = 1'b0;
    logic                prevData = 1'b0;
    logic                hpSeen = 1'b0;
    wire                 bckWire = bitClockOe ? bitClockOut : hostBck;
    wire                 wsWire = wordSelectOe ? wordSelectOut : hostWs;

    aps_serial_out uut (.sys_clk(sys_clk), .rst_n(rst_n), .pcmOutputEnable(pcmOutputEnable),
        .masterMode(masterMode), .formatSelLo(fmtSel[0]), .formatSelHi(fmtSel[1]),
        .rateModeSelLo(rateSel[0]), .rateModeSelHi(rateSel[1]), .subframeSelLo(subSel[0]),
        .subframeSelHi(subSel[1]), .filterResponseSel(filterResponseSel),
        .leftHighpassDisable(leftHpDis), .rightHighpassDisable(rightHpDis),
        .wordLengthSelLo(wlSel[0]), .wordLengthSelHi(wlSel[1]), .sampleLeft(sampleLeft),
        .sampleRight(sampleRight), .sampleValid(sampleValid), .sampleReady(sampleReady),
        .bitClockIn(bckWire), .bitClockOut(bitClockOut), .bitClockOe(bitClockOe),
        .wordSelectIn(wsWire), .wordSelectOut(wordSelectOut), .wordSelectOe(wordSelectOe),
        .serialData(serialData), .filterLowLatency(filterLowLatency),
        .groupDelaySamples(groupDelaySamples));
    aps_host_model host (.sys_clk(sys_clk), .run(run), .startOnFall(startOnFall),
        .halfSys(halfSys), .bitsPerFrame(bitsPerFrame), .linkBck(bckWire), .linkWs(wsWire),
        .serialIn(serialData), .hostBck(hostBck), .hostWs(hostWs), .frameBits(frameBits),
        .frameLen(frameLen), .frameSys(frameSys), .frameCount(frameCount));

    always #10 sys_clk = ~sys_clk;
    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    function automatic logic [31:0] xorshift(input logic [31:0] s);
        s ^= s << 13;
        s ^= s >> 17;
        s ^= s << 5;
        return s;
    endfunction
    task automatic step(input int n);
        repeat (n) @(posedge sys_clk);
        #1;
    endtask
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            bad_count++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic wrap_up();
        $display("checks=%0d mismatches=%0d", tests_run, bad_count);
        if (bad_count == 0 && tests_run > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    // shorter words only get a +-1 lsb window since the dither value is not visible
    task automatic check_word(input int off, input logic [23:0] s, input int wl,
                              input logic loose);
        logic [31:0] got;
        int          diff;
        for (int i = 0; i < 32; i++) got[31-i] = (off + i < 256) ? frameBits[off+i] : 1'b0;
        diff = ($signed(got) >>> (32 - wl)) - ($signed({s, 8'h00}) >>> (32 - wl));
        if (loose) hpSeen |= (got !== {s, 8'h00});
        else if (wl == 24) check(got, {s, 8'h00});
        else check(32'(diff >= -1 && diff <= 1 && (got << wl) == 0), 32'h1);
    endtask
    // ------------------------------------------------------------
    // source: endless random pairs, model queue of taken pairs
    // ------------------------------------------------------------
    always @(negedge sys_clk) readyPre <= sampleReady;
    always @(posedge sys_clk) begin
        if (sampleValid && readyPre) begin
            pairQ.push_back({sampleLeft, sampleRight});
            #1;
            rng = xorshift(rng);
            sampleLeft = rng[23:0];
            rng = xorshift(rng);
            sampleRight = rng[23:0];
        end
    end
    always @(posedge sys_clk) begin
        #2;
        if (masterMode && pcmOutputEnable && serialData !== prevData)
            check(32'({prevBck, bitClockOut}), 32'h2);
        prevData = serialData;
        prevBck = bitClockOut;
    end
    always @(posedge sys_clk) begin
        cycles++;
        if (cycles == 40000) begin
            bad_count++;
            wrap_up();
        end
    end
    // ------------------------------------------------------------
    // one configuration: four frames against the model
    // ------------------------------------------------------------
    task automatic run_cfg(input logic m, input logic [1:0] fmt, input logic [1:0] rate,
                           input logic [1:0] sub, input logic [1:0] wls, input logic [1:0] hpOn,
                           input int hs);
        int          bpf;
        int          d;
        int          base;
        int          half;
        int          wl;
        logic [47:0] p;
        pcmOutputEnable = 1'b0;
        run = 1'b0;
        if (cfgCount++ > 0) void'(pairQ.pop_front());
        step(3);
        check(32'({bitClockOut, wordSelectOut, serialData}), 32'h0);
        check(32'(sampleReady), 32'h0);
        masterMode = m;
        fmtSel = fmt;
        rateSel = rate;
        subSel = sub;
        wlSel = wls;
        leftHpDis = !hpOn[0];
        rightHpDis = !hpOn[1];
        halfSys = 8'(hs);
        bpf = fmt[1] ? (256 >> rate) : (m ? (rate == 2'h0 ? 128 : 64) : (512 >> rate) / (2 * hs));
        d = (fmt == FMT_I2S || fmt == FMT_TDM_DLY) ? 1 : 0;
        base = fmt[1] ? 64 * int'(sub) : 0;
        half = fmt[1] ? 32 : bpf / 2;
        wl = wls == 2'h0 ? 24 : wls == 2'h1 ? 18 : wls == 2'h2 ? 20 : 16;
        bitsPerFrame = 9'(bpf);
        startOnFall = (fmt == FMT_I2S);
        step(2);
        pcmOutputEnable = 1'b1;
        run = 1'b1;
        for (int k = 1; k <= 4; k++) begin
            while (frameCount < k) @(posedge sys_clk);
            p = pairQ.pop_front();
            check(32'(frameLen), 32'(bpf));
            check(32'(frameSys), 32'(512 >> rate));
            check_word(base + d, p[47:24], wl, hpOn[0]);
            check_word(base + half + d, p[23:0], wl, hpOn[1]);
        end
        #1;
    endtask

    initial begin
        repeat (10) @(posedge sys_clk);
        #1 check(32'({bitClockOut, wordSelectOut, serialData}), 32'h0);
        step(10);
        rst_n = 1'b1;
        sampleValid = 1'b1;
        step(1);
        for (int r = 0; r < 4; r++) begin
            for (int f = 0; f < 2; f++) begin
                rateSel = 2'(r);
                filterResponseSel = f[0];
                step(3);
                check(32'(filterLowLatency), 32'(r == 2 || f == 1));
                check(32'(groupDelaySamples), (r == 2 || f == 1) ? 32'h15 : 32'h27);
            end
        end
        run_cfg(1'b1, FMT_TDM, RATE_NORMAL, 2'h0, 2'h0, 1'b0, 1);
        run_cfg(1'b1, FMT_TDM_DLY, RATE_NORMAL, 2'h3, 2'h1, 1'b0, 1);
        run_cfg(1'b1, FMT_LJ, RATE_NORMAL, 2'h0, 2'h2, 1'b0, 1);
        run_cfg(1'b1, FMT_LJ, RATE_DOUBLE, 2'h0, 2'h3, 1'b0, 1);
        run_cfg(1'b0, FMT_TDM, RATE_DOUBLE, 2'h1, 2'h0, 1'b0, 1);
        run_cfg(1'b0, FMT_LJ, RATE_QUAD, 2'h0, 2'h0, 1'b0, 1);
        run_cfg(1'b1, FMT_TDM, RATE_QUAD, 2'h0, 2'h0, 1'b1, 1);
        check(32'(hpSeen), 32'h1);
        run_cfg(1'b0, FMT_I2S, RATE_NORMAL, 2'h0, 2'h1, 1'b0, 2);
        hpSeen = 1'b0;
        run_cfg(1'b0, FMT_LJ, RATE_NORMAL, 2'h0, 2'h0, 2'h2, 4);
        check(32'(hpSeen), 32'h1);
        wrap_up();
    end
endmodule
